// ===== pkg/ttl_pkg.sv
// Shared constants and types for the terminal test loopback block
package ttl_pkg;
  // Test command message types
  localparam logic [7:0] MSG_CLOSE      = 8'h40;
  localparam logic [7:0] MSG_CLOSE_DONE = 8'h41;
  localparam logic [7:0] MSG_OPEN       = 8'h42;
  localparam logic [7:0] MSG_OPEN_DONE  = 8'h43;
  // Loop mode octet: loop_mode_select_high/low in the two low bits
  localparam int         MODE_SEL_POS   = 0;
  localparam logic [1:0] MODE_SDU       = 2'h0;
  localparam logic [1:0] MODE_TB        = 2'h1;
  // loopback_bearer_setup_entry layout, uplink formats, delay and size limits, FIFO depth
  localparam int ENTRIES     = 4;
  localparam int SIZE_W      = 16;
  localparam int RB_W        = 5;
  localparam int TF_CNT      = 4;
  localparam int DELAY_TTI_MAX = 10;
  localparam int SDU_PER_TTI = 4;
  localparam int MAX_SDU_BITS  = 4096;
  localparam int FIFO_DEPTH  = 8;
  // Values after reset
  localparam logic RST_CLOSED = 1'b0;
  localparam logic RST_MODE2  = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_PLAY = 3'h4
  } ttl_state_t;
endpackage : ttl_pkg

// ===== core/ttl_loopback.sv
// Terminal test loopback: command handling, SDU store and uplink replay
`timescale 1ns/100ps

module ttl_loopback #(
  parameter int MAXB = ttl_pkg::MAX_SDU_BITS
) (
  input  wire logic                                       clk_sys,
  input  wire logic                                       rst_n,
  input  wire logic                                       bearerUp,
  input  wire logic                                       testModeOn,
  input  wire logic                                       cmdValid,
  input  wire logic [7:0]                                 cmdType,
  input  wire logic [7:0]                                 cmdMode,
  input  wire logic [ttl_pkg::ENTRIES-1:0]                setupValid,
  input  wire logic [ttl_pkg::ENTRIES*ttl_pkg::SIZE_W-1:0] setupSize,
  input  wire logic [ttl_pkg::ENTRIES*ttl_pkg::RB_W-1:0]  setupBearer,
  output logic                                            cfmValid,
  output logic [7:0]                                      cfmType,
  output logic                                            loopClosed,
  output logic                                            loopMode2,
  input  wire logic                                       dlValid,
  input  wire logic                                       dlBit,
  input  wire logic                                       dlLast,
  input  wire logic [ttl_pkg::RB_W-1:0]                   dlBearer,
  input  wire logic                                       dlHasPdcp,
  output logic                                            dlReady,
  input  wire logic                                       ttiTick,
  input  wire logic                                       ulVarRate,
  input  wire logic [ttl_pkg::TF_CNT*ttl_pkg::SIZE_W-1:0] tfSize,
  output logic [1:0]                                      ulTfSel,
  output logic                                            ulValid,
  output logic                                            ulBit,
  output logic                                            ulLast,
  input  wire logic                                       ulReady
);
  import ttl_pkg::*;

  localparam int AW = $clog2(MAXB);
  localparam logic [AW:0] NMAX = MAXB[AW:0];

  if (MAXB < 2 || MAXB > 32768 || (1 << AW) != MAXB) begin : gChk
    $error("MAXB must be a power of two from 2 to 32768");
  end

  typedef struct packed {
    ttl_state_t                 st;
    logic                       closed;
    logic                       mode2;
    logic [ENTRIES-1:0]         entV;
    logic [ENTRIES*SIZE_W-1:0]  entSz;
    logic [ENTRIES*RB_W-1:0]    entRb;
    logic                       pend;
    logic [7:0]                 pendType;
    logic                       cfmV;
    logic [7:0]                 cfmT;
    logic [AW:0]                n;
    logic [SIZE_W-1:0]          k;
    logic [AW-1:0]              rd;
    logic [SIZE_W-1:0]          pos;
    logic                       hit;
    logic                       pdcp;
    logic [SIZE_W-1:0]          hitSz;
    logic [1:0]                 tfSel;
    logic                       rdy;
    logic                       ulV;
    logic                       ulB;
    logic                       ulL;
  } ttl_regs_t;

  ttl_regs_t         q;
  ttl_regs_t         d;
  logic              mem [MAXB];
  logic              memWe;
  logic              fifoInV;
  logic              fifoInReady;
  logic              lastBit;
  logic              closeOk;
  logic              openOk;
  logic [ENTRIES-1:0] match;
  logic [TF_CNT-1:0]  fits;
  logic [SIZE_W-1:0]  nExt;
  logic [SIZE_W-1:0]  selSz;
  logic [SIZE_W-1:0]  len;
  logic [1:0]         sel;
  logic               fifoOutV;
  logic [1:0]         fifoOutD;
  logic               fifoOutReady;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-entry bearer match and per-format fit

  assign nExt = SIZE_W'(q.n);

  for (genvar e = 0; e < ENTRIES; e++) begin : gEnt
    assign match[e] = q.entV[e] && (q.entRb[e*RB_W +: RB_W] == dlBearer);
  end

  for (genvar f = 0; f < TF_CNT; f++) begin : gFit
    assign fits[f] = tfSize[f*SIZE_W +: SIZE_W] >= nExt;
  end

  assign closeOk = cmdValid && cmdType == MSG_CLOSE && bearerUp && testModeOn;
  assign openOk  = cmdValid && cmdType == MSG_OPEN && bearerUp;
  assign lastBit = q.pos == q.k - 1'b1;
  assign memWe   = q.st == ST_IDLE && q.closed && dlValid && q.rdy && q.n < NMAX;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d          = q;
    d.cfmV     = q.pend;
    d.cfmT     = q.pendType;
    d.pend     = 1'b0;
    fifoInV    = 1'b0;
    sel        = 2'h3;
    selSz      = '0;
    len        = '0;
    // Output stage refills whenever the sink takes or it is empty
    if (fifoOutReady) begin
      d.ulV = fifoOutV;
      d.ulB = fifoOutD[1];
      d.ulL = fifoOutD[0];
    end
    // Largest format assumed last; ascending order is the caller's duty
    for (int i = TF_CNT - 1; i >= 0; i--) begin
      if (fits[i]) begin
        sel = 2'(i);
      end
    end
    if (!ulVarRate) begin
      sel = 2'h0;
    end
    selSz = tfSize[32'(sel)*SIZE_W +: SIZE_W];
    if (closeOk) begin
      if (!q.closed) begin
        d.closed = 1'b1;
        d.mode2  = cmdMode[MODE_SEL_POS +: 2] == MODE_TB;
        d.entV   = setupValid;
        d.entSz  = setupSize;
        d.entRb  = setupBearer;
      end
      d.pend     = 1'b1;
      d.pendType = MSG_CLOSE_DONE;
    end
    if (openOk) begin
      d.closed   = 1'b0;
      d.pend     = 1'b1;
      d.pendType = MSG_OPEN_DONE;
    end
    case (q.st)
      ST_IDLE: begin
        if (dlValid && q.rdy && q.closed) begin
          // Oversized SDUs keep their head; the tail is dropped
          if (q.n < NMAX) begin
            d.n = q.n + 1'b1;
          end
          if (dlLast) begin
            d.st    = ST_WAIT;
            d.hit   = |match;
            d.pdcp  = dlHasPdcp;
            d.hitSz = '0;
            for (int i = 0; i < ENTRIES; i++) begin
              if (match[i]) begin
                d.hitSz = q.entSz[i*SIZE_W +: SIZE_W];
              end
            end
          end
        end
      end
      ST_WAIT: begin
        // Replay starts on the first tick after the SDU: one TTI, every SDU
        if (ttiTick) begin
          if (q.mode2) begin
            len     = (selSz < nExt) ? selSz : nExt;
            d.tfSel = sel;
          end else if (q.pdcp || !q.hit) begin
            len = nExt;
          end else begin
            len = q.hitSz;
          end
          d.k   = len;
          d.rd  = '0;
          d.pos = '0;
          if (len == '0 || q.n == '0) begin
            d.st = ST_IDLE;
            d.n  = '0;
          end else begin
            d.st = ST_PLAY;
          end
        end
      end
      ST_PLAY: begin
        // Bit-serial at the system clock; each SDU waits in ST_WAIT for its own tick, so at most one SDU replays per TTI
        if (fifoInReady && q.closed) begin
          fifoInV = 1'b1;
          d.pos   = q.pos + 1'b1;
          d.rd    = ((AW+1)'(q.rd) == q.n - 1'b1) ? '0 : q.rd + 1'b1;
          if (lastBit) begin
            d.st = ST_IDLE;
            d.n  = '0;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    if (!d.closed) begin
      d.st = ST_IDLE;
      d.n  = '0;
    end
    if (!bearerUp) begin
      d.closed = 1'b0;
      d.mode2  = 1'b0;
      d.entV   = '0;
      d.st     = ST_IDLE;
      d.n      = '0;
    end
    d.rdy = d.st == ST_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q        <= '0;
      q.st     <= ST_IDLE;
      q.closed <= RST_CLOSED;
      q.mode2  <= RST_MODE2;
      q.rdy    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      mem[q.n[AW-1:0]] <= dlBit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Uplink buffer; a stalled uplink holds replay and then the downlink

  // Uplink pins come from the output stage flops, not the FIFO mux
  assign fifoOutReady = !q.ulV || ulReady;

  ttl_fifo #(.W(2), .D(FIFO_DEPTH)) uFifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inValid  (fifoInV),
    .inData   ({mem[q.rd], lastBit}),
    .inReady  (fifoInReady),
    .outValid (fifoOutV),
    .outData  (fifoOutD),
    .outReady (fifoOutReady)
  );

  assign ulValid    = q.ulV;
  assign ulBit      = q.ulB;
  assign ulLast     = q.ulL;

  assign cfmValid   = q.cfmV;
  assign cfmType    = q.cfmT;
  assign loopClosed = q.closed;
  assign loopMode2  = q.mode2;
  assign dlReady    = q.rdy;
  assign ulTfSel    = q.tfSel;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cbSys @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sCloseCfm;
    cfmValid && cfmType == MSG_CLOSE_DONE;
  endsequence

  sequence sOpenCfm;
    cfmValid && cfmType == MSG_OPEN_DONE;
  endsequence

  AST_CLOSE_IGNORED: assert property (
    cmdValid && cmdType == MSG_CLOSE && !(bearerUp && testModeOn) |-> ##2 !cfmValid)
    else $error("close confirmed without bearer or test mode");
  AST_CLOSE_ORDER: assert property (sCloseCfm |-> $past(loopClosed))
    else $error("close confirmed before loop was closed");
  AST_CLOSE_AGAIN: assert property (closeOk && loopClosed |-> ##2 sCloseCfm)
    else $error("repeated close not confirmed");
  AST_RELEASE: assert property (!bearerUp |=> !loopClosed && !loopMode2)
    else $error("loop kept after bearer release");
  AST_ZERO: assert property (
    q.st == ST_WAIT && ttiTick && !q.mode2 && q.hit && !q.pdcp && q.hitSz == '0
    |=> q.st == ST_IDLE ##1 !fifoInV)
    else $error("data returned for zero uplink size");
  AST_TRUNC: assert property (
    fifoInV && q.k <= nExt |-> SIZE_W'(q.rd) == q.pos)
    else $error("truncated block not taken from its head");
  AST_WRAP: assert property (
    fifoInV && (AW+1)'(q.rd) == q.n - 1'b1 && !lastBit |=> q.rd == '0)
    else $error("padding copy does not restart at bit zero");
  AST_TF_PICK: assert property (
    q.st == ST_WAIT && ttiTick && q.mode2 && ulVarRate && q.closed && bearerUp
    |=> tfSize[32'(ulTfSel)*SIZE_W +: SIZE_W] >= $past(nExt) || ulTfSel == 2'h3)
    else $error("uplink format too small while a larger one exists");
  AST_DELAY: assert property (
    q.st == ST_WAIT && ttiTick && q.closed && bearerUp |=> q.st != ST_WAIT)
    else $error("replay did not start on the first tick");
  AST_OPEN: assert property (openOk |-> ##1 !loopClosed ##1 sOpenCfm)
    else $error("open not carried out or not confirmed");
  AST_STOP: assert property (!loopClosed |-> !fifoInV && q.st == ST_IDLE && q.n == '0)
    else $error("data looped while loop open");

endmodule : ttl_loopback

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid/ready on both sides

module ttl_fifo #(
  parameter int W = 2,
  parameter int D = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int PW = $clog2(D);

  if (D < 2 || (1 << PW) != D) begin : gChk
    $error("FIFO depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } ttl_fifo_regs_t;

  ttl_fifo_regs_t q;
  ttl_fifo_regs_t d;
  logic [W-1:0]   mem [D];
  logic           push;
  logic           pop;

  assign inReady  = q.cnt != (PW+1)'(D);
  assign outValid = q.cnt != '0;
  assign outData  = mem[q.rp];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    d     = q;
    d.wp  = push ? q.wp + 1'b1 : q.wp;
    d.rp  = pop ? q.rp + 1'b1 : q.rp;
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[q.wp] <= inData;
    end
  end

endmodule : ttl_fifo

// ===== testbench/ttl_test_sys.sv
// Test system model: stalling uplink sink and command guard timer
`timescale 1ns/100ps
module ttl_test_sys #(
  parameter int GUARD = 3
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic cmdValid,
  input  wire logic cfmValid,
  input  wire logic ulValid,
  input  wire logic ulBit,
  input  wire logic ulLast,
  output logic      ulReady
);
  int         seed     = 32'h8051df38;
  int         guardCnt = 0;
  int         timeouts = 0;
  logic [1:0] rxQ[$];
  ////////////////////////////////////////////////////////////////////////////////
  // Random stalls so the uplink FIFO really backs up
  always @(negedge clk_sys) ulReady <= |($random(seed) & 3);
  always @(posedge clk_sys) begin
    if (ulValid && ulReady) rxQ.push_back({ulLast, ulBit});
    // Guard scaled down from seconds to cycles; no ciphering on this path
    if (!rst_n) guardCnt = 0;
    else if (cmdValid) guardCnt = GUARD;
    else if (guardCnt > 0) begin
      if (cfmValid) guardCnt = 0;
      else if (guardCnt == 1) begin
        timeouts++;
        guardCnt = 0;
      end else guardCnt--;
    end
  end
endmodule : ttl_test_sys

// ===== testbench/ttl_loopback_tb_top.sv
// Testbench for the terminal test loopback block with a reference model
`timescale 1ns/100ps
module ttl_loopback_tb_top;
  import ttl_pkg::*;
  localparam int MAXB = 64;
  localparam int TTI  = 32;
  logic        clk_sys, rst_n, bearerUp, testModeOn, cmdValid, dlValid, dlBit, dlLast;
  logic        dlHasPdcp, ulVarRate, ulReady, cfmValid, loopClosed, loopMode2, dlReady;
  logic        ulValid, ulBit, ulLast;
  logic        ttiTick = 1'b0;
  logic [7:0]  cmdType, cmdMode, cfmType;
  logic [3:0]  setupValid;
  logic [63:0] setupSize, tfSize;
  logic [19:0] setupBearer;
  logic [4:0]  dlBearer;
  logic [1:0]  ulTfSel;
  int          seed = 32'h8051df38;
  int          err_total = 0, total_checks = 0, cyc = 0, expTo = 0;
  bit          mClosed, mMode2;
  bit          mVal[4];
  int          mSize[4], mRb[4];
  logic [1:0]  expQ[$];

  ttl_loopback #(.MAXB(MAXB)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .bearerUp(bearerUp),
    .testModeOn(testModeOn), .cmdValid(cmdValid), .cmdType(cmdType), .cmdMode(cmdMode),
    .setupValid(setupValid), .setupSize(setupSize), .setupBearer(setupBearer),
    .cfmValid(cfmValid), .cfmType(cfmType), .loopClosed(loopClosed), .loopMode2(loopMode2),
    .dlValid(dlValid), .dlBit(dlBit), .dlLast(dlLast), .dlBearer(dlBearer),
    .dlHasPdcp(dlHasPdcp), .dlReady(dlReady), .ttiTick(ttiTick), .ulVarRate(ulVarRate),
    .tfSize(tfSize), .ulTfSel(ulTfSel), .ulValid(ulValid), .ulBit(ulBit), .ulLast(ulLast),
    .ulReady(ulReady));
  ttl_test_sys ts (.clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid),
    .cfmValid(cfmValid), .ulValid(ulValid), .ulBit(ulBit), .ulLast(ulLast),
    .ulReady(ulReady));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) ttiTick <= (cyc % TTI) == 0;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // Model state is set at the negedge that drives the command; setup is read only when the loop was open
  task automatic cmd(input logic [7:0] t, input logic [7:0] m);
    bit acc;
    @(negedge clk_sys);
    acc = (t == MSG_CLOSE) ? (bearerUp && testModeOn) : (t == MSG_OPEN && bearerUp);
    cmdValid <= 1'b1;
    cmdType  <= t;
    cmdMode  <= m;
    if (acc && t == MSG_CLOSE && !mClosed) begin
      mMode2 = m[1:0] == MODE_TB;
      for (int k = 0; k < ENTRIES; k++) begin
        mVal[k]  = setupValid[k];
        mSize[k] = setupSize[16*k+:16];
        mRb[k]   = setupBearer[5*k+:5];
      end
    end
    if (acc) mClosed = t == MSG_CLOSE;
    else expTo++;
    @(negedge clk_sys);
    cmdValid <= 1'b0;
    chk("loopClosed", loopClosed, mClosed);
    if (mClosed) chk("loopMode2", loopMode2, mMode2);
    chk("cfm early", cfmValid, 0);
    @(negedge clk_sys);
    chk("cfmValid", cfmValid, acc);
    if (acc) chk("cfmType", cfmType, t + 8'h1);
    @(negedge clk_sys);
    chk("cfm pulse", cfmValid, 0);
  endtask : cmd

  task automatic sdu(input int n, input int rb, input bit pdcp);
    bit d[$];
    int k, sel, w, nb;
    // Bits beyond the store are consumed but not kept
    nb  = n > MAXB ? MAXB : n;
    k   = nb;
    sel = 0;
    ts.rxQ.delete();
    expQ.delete();
    @(negedge clk_sys);
    for (w = 0; !dlReady && w < 500; w++) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      d.push_back(1'($random(seed)));
      dlValid   <= 1'b1;
      dlBit     <= d[i];
      dlLast    <= i == n - 1;
      dlBearer  <= 5'(rb);
      dlHasPdcp <= pdcp;
      @(negedge clk_sys);
    end
    dlValid <= 1'b0;
    dlLast  <= 1'b0;
    if (!mClosed) k = 0;
    else if (mMode2) begin
      if (ulVarRate) begin
        sel = 3;
        for (int j = 3; j >= 0; j--) if (tfSize[16*j+:16] >= nb) sel = j;
      end
      if (tfSize[16*sel+:16] < nb) k = tfSize[16*sel+:16];
    end else if (!pdcp) begin
      for (int j = 0; j < ENTRIES; j++) if (mVal[j] && mRb[j] == rb) k = mSize[j];
    end
    for (int i = 0; i < k; i++) expQ.push_back({i == k - 1, d[i % nb]});
    for (w = 0; k > 0 && ts.rxQ.size() == 0 && w < 11 * TTI; w++) @(negedge clk_sys);
    if (k > 0) chk("delay", w <= DELAY_TTI_MAX * TTI, 1);
    for (w = 0; ts.rxQ.size() < k && w < 8 * k; w++) @(negedge clk_sys);
    // Extra wait lets any surplus uplink bits show up
    repeat (2 * TTI) @(negedge clk_sys);
    chk("ul count", ts.rxQ.size(), k);
    for (int i = 0; i < k && i < ts.rxQ.size(); i++) begin
      chk("ul bit", ts.rxQ[i], expQ[i]);
    end
    if (mClosed && mMode2) chk("ulTfSel", ulTfSel, sel);
  endtask : sdu

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; bearerUp = 1'b0; testModeOn = 1'b0; cmdValid = 1'b0;
    cmdType = 8'h00; cmdMode = 8'h00; setupValid = 4'h0; setupSize = '0; setupBearer = '0;
    dlValid = 1'b0; dlBit = 1'b0; dlLast = 1'b0; dlBearer = 5'h00; dlHasPdcp = 1'b0;
    ulVarRate = 1'b0;
    tfSize = {16'h0028, 16'h001e, 16'h0014, 16'h000c};
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("rst closed", loopClosed, RST_CLOSED);
    chk("rst mode", loopMode2, RST_MODE2);
    chk("rst ready", {dlReady, ulValid, cfmValid, ulTfSel}, 5'h10);
    cmd(MSG_CLOSE, 8'h00);
    cmd(MSG_OPEN, 8'h00);
    bearerUp <= 1'b1;
    cmd(MSG_CLOSE, 8'h00);
    cmd(MSG_OPEN, 8'h00);
    cmd(8'h44, 8'h00);
    sdu(9, 5, 1'b0);
    testModeOn  <= 1'b1;
    setupValid  <= 4'hf;
    setupBearer <= {5'h08, 5'h07, 5'h06, 5'h05};
    setupSize   <= {16'h0032, 16'h0007, 16'h0014, 16'h0000};
    cmd(MSG_CLOSE, 8'h00);
    for (int r = 0; r < 10; r++) begin
      sdu(r % 5 == 1 ? 20 : 8 + ($random(seed) & 31), 5 + r % 5, r == 5);
    end
    cmd(MSG_CLOSE, 8'h01);
    sdu(12, 9, 1'b0);
    sdu(70, 9, 1'b0);
    cmd(MSG_OPEN, 8'h00);
    cmd(MSG_CLOSE, 8'h01);
    for (int r = 0; r < 8; r++) begin
      ulVarRate <= r[0];
      sdu(1 + ($random(seed) & 31) + (r & 2) * 8, 6 + r % 3, 1'b0);
    end
    bearerUp <= 1'b0;
    repeat (2) @(negedge clk_sys);
    mClosed = 1'b0;
    mMode2  = 1'b0;
    chk("release", {loopClosed, loopMode2}, 2'h0);
    bearerUp   <= 1'b1;
    setupValid <= 4'h0;
    cmd(MSG_CLOSE, 8'h00);
    sdu(30, 7, 1'b0);
    // Reset in mid-run with the loop closed
    rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n   = 1'b1;
    mClosed = 1'b0;
    chk("mid rst", {loopClosed, loopMode2, dlReady, ulValid}, 4'h2);
    cmd(MSG_CLOSE, 8'h01);
    chk("timeouts", ts.timeouts, expTo);
    close_out();
  end
endmodule : ttl_loopback_tb_top
